// ---- core/rps_map.vh ----
// register map and field positions of the receive port status block
`ifndef RPS_MAP_VH
`define RPS_MAP_VH

`define RPS_ADDR_PORT_SELECT   8'h4C
`define RPS_ADDR_STATUS_ONE    8'h4D

`define RPS_SEL_READ_HI        5
`define RPS_SEL_READ_LO        4
`define RPS_SEL_WRITE_HI       3
`define RPS_SEL_WRITE_LO       0
`define RPS_SEL_RESET          8'h00

`define RPS_STS_PORT_HI        7
`define RPS_STS_PORT_LO        6
`define RPS_STS_CRC            5
`define RPS_STS_LOCK_CHG       4
`define RPS_STS_SEQ            3
`define RPS_STS_PARITY         2
`define RPS_STS_PASS           1
`define RPS_STS_LOCK           0
`define RPS_STS_RESET          8'h00

`define RPS_UNMAPPED_DATA      8'h00

`endif

// ---- core/rps_port_flags.v ----
// status flags of one receive port
`timescale 1ns/1ps

module rps_port_flags (
	core_clk,
	sys_rst,
	receiver_locked,
	rx_pass,
	crc_error_event,
	seq_error_event,
	enhanced_error_enable,
	parity_count_over,
	parity_counter_clear,
	detail_read,
	status_read,
	flags
);
	input  wire       core_clk;
	input  wire       sys_rst;
	input  wire       receiver_locked;
	input  wire       rx_pass;
	input  wire       crc_error_event;
	input  wire       seq_error_event;
	input  wire       enhanced_error_enable;
	input  wire       parity_count_over;
	input  wire       parity_counter_clear;
	input  wire       detail_read;
	input  wire       status_read;
	output wire [5:0] flags;

	reg lock_prev;
	reg ctrl_channel_crc_flag;
	reg lock_change_flag;
	reg ctrl_channel_sequence_flag;
	reg ctrl_channel_error_summary;
	reg parity_flag;
	reg pass_flag;
	reg lock_flag;

	wire lock_moved;

	assign lock_moved = receiver_locked ^ lock_prev;

	always @(posedge core_clk) begin
		if (sys_rst) begin
			lock_prev                  <= 1'b0;
			ctrl_channel_crc_flag      <= 1'b0;
			lock_change_flag           <= 1'b0;
			ctrl_channel_sequence_flag <= 1'b0;
			ctrl_channel_error_summary <= 1'b0;
			parity_flag                <= 1'b0;
			pass_flag                  <= 1'b0;
			lock_flag                  <= 1'b0;
		end else begin
			lock_prev <= receiver_locked;
			ctrl_channel_crc_flag <= crc_error_event | (ctrl_channel_crc_flag & ~status_read);
			lock_change_flag <= lock_moved | (lock_change_flag & ~status_read);
			ctrl_channel_sequence_flag <= seq_error_event |
				(ctrl_channel_sequence_flag & ~(status_read & ~enhanced_error_enable));
			ctrl_channel_error_summary <= (crc_error_event | seq_error_event) |
				(ctrl_channel_error_summary & ~detail_read);
			parity_flag <= parity_count_over | (parity_flag & ~parity_counter_clear);
			pass_flag <= rx_pass;
			lock_flag <= receiver_locked;
		end
	end

	assign flags = {ctrl_channel_crc_flag,
	                lock_change_flag,
	                enhanced_error_enable ? ctrl_channel_error_summary : ctrl_channel_sequence_flag,
	                parity_flag,
	                pass_flag,
	                lock_flag};
endmodule

// ---- core/rps_status.v ----
// paged receive port status register bank
`timescale 1ns/1ps
`include "rps_map.vh"

// Operation
// - bits 7:6 return the receive port currently selected for readback
// - bit 5 sets on forward control channel crc error, clears on read
// - bit 4 sets when lock state changes since last read, clears on read
// - enhanced errors off: bit 3 is sticky sequence error, cleared on read
// - enhanced errors on: bit 3 summarises errors, cleared by detail register read
// - bit 2 is one when parity error count exceeds threshold
// - reading status never clears parity flag; counter clear does
// - bit 1 shows live receive pass status
// - bit 0 shows live receiver lock state
// - status exists per port; port select chooses which copy is accessed
// - two-bit read port field picks port 0..3 and is reflected back
module rps_status #(
	parameter PORTS = 4
) (
	core_clk,
	sys_rst,
	reg_addr,
	reg_read,
	reg_write,
	reg_wdata,
	reg_rdata,
	receiver_locked,
	rx_pass,
	crc_error_event,
	seq_error_event,
	enhanced_error_enable,
	parity_count_over,
	parity_counter_clear,
	detail_read
);
	input  wire             core_clk;
	input  wire             sys_rst;
	input  wire [7:0]       reg_addr;
	input  wire             reg_read;
	input  wire             reg_write;
	input  wire [7:0]       reg_wdata;
	output reg  [7:0]       reg_rdata;
	input  wire [PORTS-1:0] receiver_locked;
	input  wire [PORTS-1:0] rx_pass;
	input  wire [PORTS-1:0] crc_error_event;
	input  wire [PORTS-1:0] seq_error_event;
	input  wire [PORTS-1:0] enhanced_error_enable;
	input  wire [PORTS-1:0] parity_count_over;
	input  wire [PORTS-1:0] parity_counter_clear;
	input  wire [PORTS-1:0] detail_read;

	// read-only top bits of the port select register read back as zero here
	localparam [1:0] SEL_PHYS_PORT = 2'h0;
	localparam [7:0] SEL_RESET     = `RPS_SEL_RESET;
	localparam       FLAG_BITS     = 6;
	// bit places inside the six flags of one port, as packed by rps_port_flags
	localparam       FLAG_CRC      = 5;
	localparam       FLAG_LOCK_CHG = 4;
	localparam       FLAG_ERROR    = 3;
	localparam       FLAG_PARITY   = 2;
	localparam       FLAG_PASS     = 1;
	localparam       FLAG_LOCK     = 0;

	reg  [1:0]                 read_port;
	reg  [3:0]                 write_port_enable;
	reg  [7:0]                 next_rdata;
	wire [7:0]                 port_select;
	wire [PORTS*FLAG_BITS-1:0] all_flags;
	wire [FLAG_BITS-1:0]       read_flags;
	wire [PORTS-1:0]           status_read;
	wire                       select_hit;
	wire                       status_hit;
	wire                       select_write;
	wire                       status_access;
	wire                       ctrl_channel_crc_flag;
	wire                       lock_change_flag;
	wire                       ctrl_channel_error_bit;
	wire                       parity_flag;
	wire                       pass_flag;
	wire                       lock_flag;

	// address decode shared by writes and clear-on-read; readback decodes reg_addr in its own case
	function addr_is_select;
		input [7:0] addr;
		begin
			addr_is_select = (addr == `RPS_ADDR_PORT_SELECT);
		end
	endfunction

	function addr_is_status;
		input [7:0] addr;
		begin
			addr_is_status = (addr == `RPS_ADDR_STATUS_ONE);
		end
	endfunction

	// one port's flags out of the packed vector; absent ports read as zero
	function [FLAG_BITS-1:0] port_flags_of;
		input [PORTS*FLAG_BITS-1:0] flags_all;
		input [1:0]                 which;
		integer                     k;
		begin
			port_flags_of = {FLAG_BITS{1'b0}};
			for (k = 0; k < PORTS; k = k + 1) begin
				if (which == k) begin
					port_flags_of = flags_all[k*FLAG_BITS +: FLAG_BITS];
				end
			end
		end
	endfunction

	// status byte with every flag in its own bit place
	function [7:0] status_byte;
		input [1:0] which;
		input       crc;
		input       lock_change;
		input       error;
		input       parity;
		input       pass;
		input       lock;
		begin
			status_byte                                    = `RPS_STS_RESET;
			status_byte[`RPS_STS_PORT_HI:`RPS_STS_PORT_LO] = which;
			status_byte[`RPS_STS_CRC]                      = crc;
			status_byte[`RPS_STS_LOCK_CHG]                 = lock_change;
			status_byte[`RPS_STS_SEQ]                      = error;
			status_byte[`RPS_STS_PARITY]                   = parity;
			status_byte[`RPS_STS_PASS]                     = pass;
			status_byte[`RPS_STS_LOCK]                     = lock;
		end
	endfunction

	function [7:0] select_byte;
		input [1:0] which;
		input [3:0] enables;
		begin
			select_byte                                      = SEL_RESET;
			select_byte[7:6]                                 = SEL_PHYS_PORT;
			select_byte[`RPS_SEL_READ_HI:`RPS_SEL_READ_LO]   = which;
			select_byte[`RPS_SEL_WRITE_HI:`RPS_SEL_WRITE_LO] = enables;
		end
	endfunction

	// strobes qualified by address
	assign select_hit    = addr_is_select(reg_addr);
	assign status_hit    = addr_is_status(reg_addr);
	assign select_write  = reg_write && select_hit;
	assign status_access = reg_read && status_hit;

	always @(posedge core_clk) begin
		if (sys_rst) begin
			read_port         <= SEL_RESET[`RPS_SEL_READ_HI:`RPS_SEL_READ_LO];
			write_port_enable <= SEL_RESET[`RPS_SEL_WRITE_HI:`RPS_SEL_WRITE_LO];
		end else if (select_write) begin
			read_port         <= reg_wdata[`RPS_SEL_READ_HI:`RPS_SEL_READ_LO];
			write_port_enable <= reg_wdata[`RPS_SEL_WRITE_HI:`RPS_SEL_WRITE_LO];
		end
	end

	// write enables kept for readback only: no per-port field here is writable
	assign port_select = select_byte(read_port, write_port_enable);

	genvar g;
	generate
		for (g = 0; g < PORTS; g = g + 1) begin : port
			// clear on read hits only the selected copy
			assign status_read[g] = status_access && (read_port == g);
			rps_port_flags u_flags (
				.core_clk              (core_clk),
				.sys_rst               (sys_rst),
				.receiver_locked       (receiver_locked[g]),
				.rx_pass               (rx_pass[g]),
				.crc_error_event       (crc_error_event[g]),
				.seq_error_event       (seq_error_event[g]),
				.enhanced_error_enable (enhanced_error_enable[g]),
				.parity_count_over     (parity_count_over[g]),
				.parity_counter_clear  (parity_counter_clear[g]),
				.detail_read           (detail_read[g]),
				.status_read           (status_read[g]),
				.flags                 (all_flags[g*6+5:g*6])
			);
		end
	endgenerate

	assign read_flags             = port_flags_of(all_flags, read_port);
	assign ctrl_channel_crc_flag  = read_flags[FLAG_CRC];
	assign lock_change_flag       = read_flags[FLAG_LOCK_CHG];
	assign ctrl_channel_error_bit = read_flags[FLAG_ERROR];
	assign parity_flag            = read_flags[FLAG_PARITY];
	assign pass_flag              = read_flags[FLAG_PASS];
	assign lock_flag              = read_flags[FLAG_LOCK];

	// readback mux; unmapped addresses read as zero
	always @* begin
		next_rdata = reg_rdata;
		if (reg_read) begin
			case (reg_addr)
				`RPS_ADDR_PORT_SELECT: begin
					next_rdata = port_select;
				end
				`RPS_ADDR_STATUS_ONE: begin
					next_rdata = status_byte(read_port, ctrl_channel_crc_flag, lock_change_flag,
					                         ctrl_channel_error_bit, parity_flag, pass_flag, lock_flag);
				end
				default: begin
					next_rdata = `RPS_UNMAPPED_DATA;
				end
			endcase
		end
	end

	// read data stands until the next read
	always @(posedge core_clk) begin
		if (sys_rst) begin
			reg_rdata <= `RPS_STS_RESET;
		end else begin
			reg_rdata <= next_rdata;
		end
	end
endmodule

// ---- tb/rps_status_monitor.sv ----
// assertions on the receive port status bank ports
`timescale 1ns/1ps
module rps_status_monitor #(
	parameter PORTS = 4
) (
	input wire             core_clk,
	input wire             sys_rst,
	input wire [7:0]       reg_addr,
	input wire             reg_read,
	input wire             reg_write,
	input wire [7:0]       reg_wdata,
	input wire [7:0]       reg_rdata,
	input wire [PORTS-1:0] receiver_locked,
	input wire [PORTS-1:0] rx_pass,
	input wire [PORTS-1:0] crc_error_event,
	input wire [PORTS-1:0] seq_error_event,
	input wire [PORTS-1:0] parity_count_over
);
	reg  [1:0]         sel;
	reg  [5*PORTS-1:0] q;
	wire               rs = reg_read && reg_addr == 8'h4D;
	wire [4:0]         v = {q[4*PORTS+sel], q[3*PORTS+sel], q[2*PORTS+sel], q[PORTS+sel], q[sel]};
	// selected port and inputs as the flags last saw them
	always @(posedge core_clk) begin
		if (sys_rst) begin
			sel <= 2'h0;
			q <= {5*PORTS{1'b0}};
		end else begin
			q <= {seq_error_event, crc_error_event, parity_count_over, rx_pass, receiver_locked};
			if (reg_write && reg_addr == 8'h4C)
				sel <= reg_wdata[5:4];
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	property p_port; rs |=> reg_rdata[7:6] == $past(sel); endproperty
	a_port: assert property (p_port) else $error("port field");
	property p_lock; rs |=> reg_rdata[0] == $past(v[0]); endproperty
	a_lock: assert property (p_lock) else $error("lock bit");
	property p_pass; rs |=> reg_rdata[1] == $past(v[1]); endproperty
	a_pass: assert property (p_pass) else $error("pass bit");
	property p_par; rs && v[2] |=> reg_rdata[2]; endproperty
	a_par: assert property (p_par) else $error("parity bit");
	property p_crc; rs && v[3] |=> reg_rdata[5]; endproperty
	a_crc: assert property (p_crc) else $error("crc bit");
	property p_seq; rs && v[4] |=> reg_rdata[3]; endproperty
	a_seq: assert property (p_seq) else $error("error bit");
	property p_clr; rs && !reg_write && !crc_error_event[sel] ##1 !reg_write && !crc_error_event[sel]
		##1 rs |=> !reg_rdata[5]; endproperty
	a_clr: assert property (p_clr) else $error("crc not cleared");
	property p_hold; !reg_read |=> $stable(reg_rdata); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
endmodule
bind rps_status rps_status_monitor #(.PORTS(PORTS)) mon_u (
	.core_clk          (core_clk),
	.sys_rst           (sys_rst),
	.reg_addr          (reg_addr),
	.reg_read          (reg_read),
	.reg_write         (reg_write),
	.reg_wdata         (reg_wdata),
	.reg_rdata         (reg_rdata),
	.receiver_locked   (receiver_locked),
	.rx_pass           (rx_pass),
	.crc_error_event   (crc_error_event),
	.seq_error_event   (seq_error_event),
	.parity_count_over (parity_count_over)
);

// ---- tb/rps_serializer_model.sv ----
// far-end serializer model: lock, pass and error events
`timescale 1ns/1ps
module rps_serializer_model (
	input  wire       core_clk,
	output reg  [3:0] receiver_locked,
	output reg  [3:0] rx_pass,
	output reg  [3:0] crc_error_event,
	output reg  [3:0] seq_error_event
);
	initial {receiver_locked, rx_pass, crc_error_event, seq_error_event} = 16'h0000;
	task send(input [15:0] v);
		@(negedge core_clk) {receiver_locked, rx_pass, crc_error_event, seq_error_event} = v;
	endtask
endmodule

// ---- tb/rps_status_tb.sv ----
// self-checking bench for the receive port status bank
`timescale 1ns/1ps
module rps_status_tb;
	reg         core_clk = 1'b0, sys_rst = 1'b1, reg_read = 1'b0, reg_write = 1'b0;
	reg  [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00;
	reg  [3:0]  enhanced_error_enable = 4'h0, parity_count_over = 4'h0, parity_counter_clear = 4'h0;
	reg  [3:0]  detail_read = 4'h0, lk = 4'h0, chg = 4'h0, par = 4'h0;
	wire [7:0]  reg_rdata;
	wire [3:0]  receiver_locked, rx_pass, crc_error_event, seq_error_event;
	reg  [13:0] rows [0:3];
	integer     mismatches = 0, checks_done = 0, i, n;
	rps_serializer_model ser_u (
		.core_clk        (core_clk),
		.receiver_locked (receiver_locked),
		.rx_pass         (rx_pass),
		.crc_error_event (crc_error_event),
		.seq_error_event (seq_error_event)
	);
	rps_status dut_u (
		.core_clk              (core_clk),
		.sys_rst               (sys_rst),
		.reg_addr              (reg_addr),
		.reg_read              (reg_read),
		.reg_write             (reg_write),
		.reg_wdata             (reg_wdata),
		.reg_rdata             (reg_rdata),
		.receiver_locked       (receiver_locked),
		.rx_pass               (rx_pass),
		.crc_error_event       (crc_error_event),
		.seq_error_event       (seq_error_event),
		.enhanced_error_enable (enhanced_error_enable),
		.parity_count_over     (parity_count_over),
		.parity_counter_clear  (parity_counter_clear),
		.detail_read           (detail_read)
	);
	initial forever #20 core_clk = ~core_clk;
	task tally_and_finish;
		begin
			$display("checks %0d mismatches %0d", checks_done, mismatches);
			if (mismatches == 0 && checks_done > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	task bus(input w, input [7:0] a, input [7:0] d);
		begin
			@(negedge core_clk) {reg_write, reg_read, reg_addr, reg_wdata} = {w, !w, a, d};
			@(negedge core_clk) {reg_write, reg_read} = 2'b00;
		end
	endtask
	task check(input [7:0] a, input [7:0] e);
		begin
			bus(1'b0, a, 8'h00);
			checks_done = checks_done + 1;
			if (reg_rdata !== e) begin
				mismatches = mismatches + 1;
				$display("unexpected at %0t got %h want %h", $time, reg_rdata, e);
			end
		end
	endtask
	initial begin
		rows[0] = {2'h0, 4'h1, 4'h1, 4'h0};
		rows[1] = {2'h1, 4'h3, 4'h0, 4'h2};
		rows[2] = {2'h3, 4'hB, 4'h8, 4'h0};
		rows[3] = {2'h1, 4'h1, 4'h2, 4'h0};
		repeat (10) @(negedge core_clk);
		sys_rst = 1'b0;
		check(8'h4D, 8'h00);
		for (i = 0; i < 4; i = i + 1) begin
			n = rows[i][13:12];
			chg = chg | (rows[i][11:8] ^ lk);
			lk = rows[i][11:8];
			par = par | rows[i][3:0];
			parity_count_over = rows[i][3:0];
			ser_u.send({rows[i][11:4], 8'h00});
			bus(1'b1, 8'h4C, {2'h0, rows[i][13:12], 4'h0});
			check(8'h4D, {rows[i][13:12], 1'b0, chg[n], 1'b0, par[n], rows[i][4+n], lk[n]});
			chg[n] = 1'b0;
		end
		fork
			ser_u.send(16'h1222);
			check(8'h4D, 8'h46);
		join
		check(8'h4D, 8'h6E);
		ser_u.send(16'h1200);
		check(8'h4D, 8'h6E);
		check(8'h4D, 8'h46);
		enhanced_error_enable = 4'h2;
		@(negedge core_clk) detail_read = 4'h2;
		@(negedge core_clk) detail_read = 4'h0;
		check(8'h4D, 8'h46);
		ser_u.send(16'h1202);
		ser_u.send(16'h1200);
		check(8'h4D, 8'h4E);
		check(8'h4D, 8'h4E);
		@(negedge core_clk) detail_read = 4'h2;
		@(negedge core_clk) detail_read = 4'h0;
		check(8'h4D, 8'h46);
		@(negedge core_clk) parity_counter_clear = 4'h2;
		@(negedge core_clk) parity_counter_clear = 4'h0;
		check(8'h4D, 8'h42);
		bus(1'b1, 8'h4D, 8'hFF);
		check(8'h4D, 8'h42);
		check(8'h4E, 8'h00);
		check(8'h4C, 8'h10);
		bus(1'b1, 8'h4C, 8'h30);
		check(8'h4D, 8'hD0);
		check(8'h4D, 8'hC0);
		ser_u.send(16'h0010);
		ser_u.send(16'h0000);
		@(negedge core_clk) sys_rst = 1'b1;
		repeat (3) @(negedge core_clk);
		sys_rst = 1'b0;
		check(8'h4C, 8'h00);
		check(8'h4D, 8'h00);
		tally_and_finish;
	end
endmodule
